// *** hw/scu_pkg.sv ***
// Shared constants and types for the sensor command unit
package scu_pkg;

    // Bus address and command codes
    localparam logic [6:0] DEV_ADDR = 7'h76;
    localparam logic [7:0] CMD_RESET = 8'h1e;
    localparam logic [7:0] CMD_ADC_READ = 8'h00;
    localparam logic [7:0] CMD_PROM_FIRST = 8'ha0;
    localparam logic [7:0] CMD_PROM_LAST = 8'hae;
    localparam logic [7:0] CMD_CONVERSION_SELECT_BIT_P_FIRST = 8'h40;
    localparam logic [7:0] CMD_CONVERSION_SELECT_BIT_P_LAST = 8'h4a;
    localparam logic [7:0] CMD_CONVERSION_SELECT_BIT_T_FIRST = 8'h50;
    localparam logic [7:0] CMD_CONVERSION_SELECT_BIT_T_LAST = 8'h5a;

    // Command byte fields (bit 7 is sent first)
    localparam int CMD_PROM_BIT = 7;
    localparam int CMD_CONVERSION_SELECT_BIT_BIT = 6;
    localparam int CMD_TYPE_BIT = 4;
    localparam int CMD_SEL_LSB = 1;
    localparam int CMD_SEL_W = 3;
    localparam logic [2:0] OSR_SEL_MAX = 3'h5;

    // Calibration memory layout
    localparam int PROM_WORDS = 7;
    localparam int PROM_W = 16;
    localparam int CRC_LSB = 12;
    localparam int CRC_W = 4;
    localparam logic [15:0] CRC_WORD0_MASK = 16'h0fff;
    localparam logic [15:0] CRC_POLY = 16'h3000;
    localparam int CRC_BYTES = 16;

    // Transfer lengths
    localparam int RESULT_W = 24;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Conversion timing on the oscillator clock
    localparam int OSC_PERIOD_PS = 12000;
    localparam int CONVERSION_SELECT_BIT_TIME_256_PS = 540000000;
    localparam int CONVERSION_SELECT_BIT_CYCLES_256 = (CONVERSION_SELECT_BIT_TIME_256_PS + OSC_PERIOD_PS - 1) / OSC_PERIOD_PS;
    localparam int CONVERSION_SELECT_BIT_CNT_W = 24;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_WRITE,
        ST_ACK_WRITE,
        ST_READ,
        ST_ACK_READ
    } scu_bus_state_t;

endpackage : scu_pkg

// *** hw/scu_sync.sv ***
// Two-flop synchroniser for a single level
`timescale 1ns/1ns
`default_nettype none
module scu_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk, // Destination clock
    input wire logic rstn, // Async reset, active low
    input wire logic d, // Level from another domain
    output logic q // Synchronised level
);
    logic meta_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : scu_sync
`default_nettype wire

// *** hw/scu_crc4.sv ***
// Check code over the calibration image
`timescale 1ns/1ns
`default_nettype none
module scu_crc4
    import scu_pkg::*;
(
    input wire logic [PROM_WORDS*PROM_W-1:0] image, // Word i at bits 16i+15..16i
    output logic [CRC_W-1:0] crc // Top four remainder bits
);
    function automatic logic [CRC_W-1:0] calc_crc(input logic [PROM_WORDS*PROM_W-1:0] w);
        logic [15:0] rem;
        logic [15:0] word;
        int c;
        int n;
        rem = 16'h0000;
        word = 16'h0000;
        for (c = 0; c < CRC_BYTES; c++) begin
            // Word 7 does not exist and counts as zero
            word = ((c >> 1) < PROM_WORDS) ? w[(c >> 1)*PROM_W +: PROM_W] : 16'h0000;
            if ((c >> 1) == 0) begin
                word = word & CRC_WORD0_MASK;
            end
            rem = rem ^ ((c % 2 == 1) ? {8'h00, word[7:0]} : {8'h00, word[15:8]});
            for (n = 0; n < 8; n++) begin
                rem = rem[15] ? ((rem << 1) ^ CRC_POLY) : (rem << 1);
            end
        end
        return rem[15:CRC_LSB];
    endfunction : calc_crc

    assign crc = calc_crc(image);
endmodule : scu_crc4
`default_nettype wire

// *** hw/scu_cmd_unit.sv ***
// Bus-side command interpreter of the pressure sensor
// What this block does
// - Answer bus address 1110110; direction bit low writes, high reads.
// - Each command is one byte, decoded alone.
// - Result read returns 24 bits; calibration read returns 16 bits.
// - Calibration word index sits in bits 1..3, codes 0xA0 to 0xAE.
// - Pressure 0x40-0x4A, temperature 0x50-0x5A; ratios 256 up to 8192.
// - Reset 0x1E reloads calibration memory into the internal register.
// - Reset command is accepted at any moment, even mid conversion.
// - Calibration memory holds seven 16-bit words.
// - Calibration read is a command write, then a read transaction.
// - Calibration word goes out most significant bit first.
// - Result read 0x00 returns latest result, MSB first.
// - No new conversion or repeated read returns zero.
// - Read during conversion returns zero; conversion continues, result corrupted.
// - Conversion command during a conversion corrupts the result.
// - Conversion command starts pressure or temperature conversion as coded.
// - Device stays busy until the conversion has finished or a reset command 0x1E clears it.
// - Device waits for host acknowledge after every byte it sends.
// - Word 0 bits 12..15 hold the check code.
// - Words 1..6 hold the six calibration coefficients.
// - Check code is the bytewise remainder over eight words.
`timescale 1ns/1ns
`default_nettype none
module scu_cmd_unit
    import scu_pkg::*;
#(
    parameter int CONVERSION_SELECT_BIT_CYCLES = CONVERSION_SELECT_BIT_CYCLES_256,
    parameter logic [PROM_WORDS*PROM_W-1:0] FACTORY_IMAGE = {PROM_WORDS{16'h1234}}
) (
    input wire logic sys_clk, // Bus-side clock
    input wire logic rstn, // Async reset, active low
    input wire logic osc_clk, // Conversion oscillator clock
    input wire logic scl_in, // Bus clock pin
    input wire logic sda_in, // Bus data pin level
    output logic sda_out, // Bus data drive value
    output logic sda_oe, // High while pulling data low
    input wire logic [RESULT_W-1:0] adc_data, // Converter word, osc_clk domain
    output logic conversion_select_bit_active, // Conversion running, osc_clk domain
    output logic conversion_select_bit_is_temp, // Running conversion is temperature
    output logic [CMD_SEL_W-1:0] conversion_select_bit_ratio // Ratio code of running conversion
);
    // Bus pin sampling
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;

    scu_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .clk(sys_clk),
        .rstn(rstn),
        .d(scl_in),
        .q(scl_s)
    );

    scu_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .clk(sys_clk),
        .rstn(rstn),
        .d(sda_in),
        .q(sda_s)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // Bus state machine
    scu_bus_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg;
    logic got_ack_reg;
    logic sda_oe_reg;
    logic sda_out_reg;
    logic cmd_pulse_reg;
    logic [RESULT_W-1:0] tx_reg;
    logic [RESULT_W-1:0] tx_load;

    wire addr_hit = (shift_reg[7:1] == DEV_ADDR);
    wire byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            got_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            cmd_pulse_reg <= 1'b0;
            tx_reg <= '0;
        end else begin
            cmd_pulse_reg <= 1'b0;
            if (cmd_pulse_reg) begin
                tx_reg <= tx_load;
            end
            if (start_det) begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (byte_done) begin
                            if (state_reg == ST_WRITE) begin
                                sda_oe_reg <= 1'b1;
                                cmd_pulse_reg <= 1'b1;
                                state_reg <= ST_ACK_WRITE;
                            end else if (addr_hit) begin
                                sda_oe_reg <= 1'b1;
                                rw_reg <= shift_reg[0];
                                state_reg <= ST_ACK_ADDR;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                sda_oe_reg <= ~tx_reg[RESULT_W-1];
                                tx_reg <= {tx_reg[RESULT_W-2:0], 1'b0};
                                bit_cnt_reg <= 4'h1;
                                state_reg <= ST_READ;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                bit_cnt_reg <= 4'h0;
                                state_reg <= ST_WRITE;
                            end
                        end
                    end
                    ST_ACK_WRITE: begin
                        if (scl_fall) begin
                            sda_oe_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (byte_done) begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_ACK_READ;
                        end else if (scl_fall) begin
                            sda_oe_reg <= ~tx_reg[RESULT_W-1];
                            tx_reg <= {tx_reg[RESULT_W-2:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    ST_ACK_READ: begin
                        if (scl_rise) begin
                            got_ack_reg <= ~sda_s;
                        end
                        if (scl_fall) begin
                            // Next byte only after the host's acknowledge
                            if (got_ack_reg) begin
                                sda_oe_reg <= ~tx_reg[RESULT_W-1];
                                tx_reg <= {tx_reg[RESULT_W-2:0], 1'b0};
                                bit_cnt_reg <= 4'h1;
                                state_reg <= ST_READ;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sda_out_reg <= 1'b0;
        end else begin
            sda_out_reg <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_reg;
    assign sda_out = sda_out_reg;

    // Command decode
    wire [7:0] cmd = shift_reg;
    wire [CMD_SEL_W-1:0] cmd_sel = cmd[CMD_SEL_LSB +: CMD_SEL_W];
    wire is_reset = (cmd == CMD_RESET);
    wire is_adc_read = (cmd == CMD_ADC_READ);
    wire is_prom = cmd[CMD_PROM_BIT] && (cmd >= CMD_PROM_FIRST) && (cmd <= CMD_PROM_LAST) && !cmd[0];
    wire is_conversion_select_bit_p = (cmd >= CMD_CONVERSION_SELECT_BIT_P_FIRST) && (cmd <= CMD_CONVERSION_SELECT_BIT_P_LAST) && !cmd[0];
    wire is_conversion_select_bit_t = (cmd >= CMD_CONVERSION_SELECT_BIT_T_FIRST) && (cmd <= CMD_CONVERSION_SELECT_BIT_T_LAST) && !cmd[0];
    wire is_conversion_select_bit = cmd[CMD_CONVERSION_SELECT_BIT_BIT] && (is_conversion_select_bit_p || is_conversion_select_bit_t);

    // Calibration memory and its working copy
    logic [PROM_W-1:0] prom_reg [0:PROM_WORDS-1];
    logic [CRC_W-1:0] crc_val;

    scu_crc4 u_crc4 (
        .image(FACTORY_IMAGE),
        .crc(crc_val)
    );

    // Index 7 has no word behind it and reads as zero
    wire [PROM_W-1:0] prom_word = (cmd_sel < CMD_SEL_W'(PROM_WORDS)) ? prom_reg[cmd_sel] : 16'h0000;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < PROM_WORDS; i++) begin
                prom_reg[i] <= 16'h0000;
            end
        end else if (cmd_pulse_reg && is_reset) begin
            for (int i = 0; i < PROM_WORDS; i++) begin
                prom_reg[i] <= FACTORY_IMAGE[i*PROM_W +: PROM_W];
            end
            prom_reg[0][PROM_W-1:CRC_LSB] <= crc_val;
        end
    end

    // Conversion bookkeeping, bus side
    logic busy_reg;
    logic valid_reg;
    logic corrupt_reg;
    logic discard_reg;
    logic start_tgl_reg;
    logic type_reg;
    logic [CMD_SEL_W-1:0] osr_reg;
    logic [RESULT_W-1:0] result_reg;
    logic done_s;
    logic done_d_reg;
    logic [RESULT_W-1:0] osc_result_reg;
    logic done_tgl_reg;

    scu_sync u_done_sync (
        .clk(sys_clk),
        .rstn(rstn),
        .d(done_tgl_reg),
        .q(done_s)
    );

    wire done_evt = done_s ^ done_d_reg;
    wire conversion_select_bit_ok = is_conversion_select_bit && (cmd_sel <= OSR_SEL_MAX);

    // Result read gives zero unless a finished, unread result exists
    assign tx_load = is_adc_read ? ((valid_reg && !busy_reg) ? result_reg : '0) :
        is_prom ? {prom_word, 8'h00} : '0;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            valid_reg <= 1'b0;
            corrupt_reg <= 1'b0;
            discard_reg <= 1'b0;
            start_tgl_reg <= 1'b0;
            type_reg <= 1'b0;
            osr_reg <= '0;
            result_reg <= '0;
            done_d_reg <= 1'b0;
        end else begin
            done_d_reg <= done_s;
            if (cmd_pulse_reg) begin
                if (is_reset) begin
                    busy_reg <= 1'b0;
                    valid_reg <= 1'b0;
                    discard_reg <= busy_reg;
                end else if (is_adc_read) begin
                    valid_reg <= 1'b0;
                    if (busy_reg) begin
                        corrupt_reg <= 1'b1;
                    end
                end else if (conversion_select_bit_ok) begin
                    if (busy_reg) begin
                        corrupt_reg <= 1'b1;
                    end else begin
                        busy_reg <= 1'b1;
                        corrupt_reg <= 1'b0;
                        valid_reg <= 1'b0;
                        type_reg <= cmd[CMD_TYPE_BIT];
                        osr_reg <= cmd_sel;
                        start_tgl_reg <= ~start_tgl_reg;
                    end
                end
            end
            // Completion wins over a clear in the same cycle
            if (done_evt) begin
                if (discard_reg) begin
                    discard_reg <= 1'b0;
                end else begin
                    busy_reg <= 1'b0;
                    valid_reg <= 1'b1;
                    result_reg <= corrupt_reg ? ~osc_result_reg : osc_result_reg;
                end
            end
        end
    end

    // Conversion timer, oscillator side
    logic start_s;
    logic start_d_reg;
    logic [CONVERSION_SELECT_BIT_CNT_W-1:0] cnt_reg;
    logic active_reg;
    logic is_temp_reg;
    logic [CMD_SEL_W-1:0] ratio_reg;

    scu_sync u_start_sync (
        .clk(osc_clk),
        .rstn(rstn),
        .d(start_tgl_reg),
        .q(start_s)
    );

    // Each ratio step doubles the conversion time
    function automatic logic [CONVERSION_SELECT_BIT_CNT_W-1:0] conversion_select_bit_len(input logic [CMD_SEL_W-1:0] sel);
        return CONVERSION_SELECT_BIT_CNT_W'(CONVERSION_SELECT_BIT_CYCLES) << sel;
    endfunction : conversion_select_bit_len

    // Type and ratio are stable on the bus side while the toggle crosses
    always_ff @(posedge osc_clk or negedge rstn) begin
        if (!rstn) begin
            start_d_reg <= 1'b0;
            cnt_reg <= '0;
            active_reg <= 1'b0;
            is_temp_reg <= 1'b0;
            ratio_reg <= '0;
            osc_result_reg <= '0;
            done_tgl_reg <= 1'b0;
        end else begin
            start_d_reg <= start_s;
            if (start_s ^ start_d_reg) begin
                active_reg <= 1'b1;
                is_temp_reg <= type_reg;
                ratio_reg <= osr_reg;
                cnt_reg <= conversion_select_bit_len(osr_reg);
            end else if (active_reg) begin
                cnt_reg <= cnt_reg - CONVERSION_SELECT_BIT_CNT_W'(1);
                if (cnt_reg <= CONVERSION_SELECT_BIT_CNT_W'(1)) begin
                    active_reg <= 1'b0;
                    osc_result_reg <= adc_data;
                    done_tgl_reg <= ~done_tgl_reg;
                end
            end
        end
    end

    assign conversion_select_bit_active = active_reg;
    assign conversion_select_bit_is_temp = is_temp_reg;
    assign conversion_select_bit_ratio = ratio_reg;

endmodule : scu_cmd_unit
`default_nettype wire

// *** dv/scu_cmd_unit_checker.sv ***
// Port assertions for the sensor command unit
`timescale 1ns/1ns
`default_nettype none
module scu_cmd_unit_checker #(
    parameter int CONVERSION_SELECT_BIT_CYCLES = 20
) (
    input wire logic sys_clk, // Bus clock
    input wire logic rstn, // Reset
    input wire logic osc_clk, // Osc clock
    input wire logic scl_in, // Bus clock pin
    input wire logic sda_in, // Data wire
    input wire logic sda_out, // Data drive
    input wire logic sda_oe, // Data pull
    input wire logic [23:0] adc_data, // Converter word
    input wire logic conversion_select_bit_active, // Busy
    input wire logic conversion_select_bit_is_temp, // Kind
    input wire logic [2:0] conversion_select_bit_ratio // Ratio code
);
    logic [31:0] len_reg;
    logic [7:0] low_reg;
    always_ff @(posedge osc_clk or negedge rstn) begin
        if (!rstn) len_reg <= 32'h0;
        else len_reg <= conversion_select_bit_active ? len_reg + 32'h1 : 32'h0;
    end
    // A stuck data line would let this count on until it wraps past 255
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) low_reg <= 8'h0;
        else low_reg <= sda_oe ? low_reg + 8'h1 : 8'h0;
    end
    AST_SDA_OUT_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) sda_out == 1'h0)
        else $error("data drive value not low");
    AST_OE_RISE_SCL_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) $rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    AST_OE_FALL_SCL_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) $fell(sda_oe) |-> !scl_in)
        else $error("data released while clock high");
    AST_OE_STABLE_SCL_HIGH: assert property (@(posedge sys_clk) disable iff (!rstn)
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed in clock high phase");
    AST_OE_RUN_BOUND: assert property (@(posedge sys_clk) disable iff (!rstn) sda_oe |-> low_reg < 8'hfa)
        else $error("data line held low too long");
    AST_RATIO_RANGE: assert property (@(posedge osc_clk) disable iff (!rstn) conversion_select_bit_active |-> conversion_select_bit_ratio <= 3'h5)
        else $error("ratio code out of range");
    AST_CONVERSION_SELECT_BIT_ATTR_STABLE: assert property (@(posedge osc_clk) disable iff (!rstn)
        conversion_select_bit_active && $past(conversion_select_bit_active) |-> $stable(conversion_select_bit_ratio) && $stable(conversion_select_bit_is_temp))
        else $error("conversion kind changed while running");
    AST_CONVERSION_SELECT_BIT_LEN: assert property (@(posedge osc_clk) disable iff (!rstn)
        $fell(conversion_select_bit_active) |-> len_reg == (CONVERSION_SELECT_BIT_CYCLES << $past(conversion_select_bit_ratio)))
        else $error("conversion length wrong");
    COV_CONVERSION_SELECT_BIT_DONE: cover property (@(posedge osc_clk) disable iff (!rstn) $fell(conversion_select_bit_active));
    COV_TEMP_TOP: cover property (@(posedge osc_clk) disable iff (!rstn) conversion_select_bit_active && conversion_select_bit_is_temp && conversion_select_bit_ratio == 3'h5);
    COV_OE_RISE: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(sda_oe));
endmodule : scu_cmd_unit_checker
bind scu_cmd_unit scu_cmd_unit_checker #(.CONVERSION_SELECT_BIT_CYCLES(CONVERSION_SELECT_BIT_CYCLES)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .osc_clk(osc_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .adc_data(adc_data), .conversion_select_bit_active(conversion_select_bit_active), .conversion_select_bit_is_temp(conversion_select_bit_is_temp), .conversion_select_bit_ratio(conversion_select_bit_ratio));
`default_nettype wire

// *** dv/scu_host_model.sv ***
// Bus master model standing in for the host controller
`timescale 1ns/1ns
`default_nettype none
module scu_host_model (
    input wire logic sys_clk, // Pacing clock
    input wire logic sda, // Resolved data wire
    output logic scl, // Bus clock
    output logic sda_low // Pull data low
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // Ten cycles keeps each phase above the oversampling minimum
    task automatic half;
        repeat (10) @(negedge sys_clk);
    endtask : half
    task automatic bit_io(input logic d, output logic s);
        sda_low = !d;
        half();
        scl = 1'h1;
        half();
        s = sda;
        scl = 1'h0;
        repeat (2) @(negedge sys_clk);
    endtask : bit_io
    task automatic io_byte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    endtask : io_byte
    task automatic xfer(input logic [7:0] addr, input logic [7:0] c, input int nrd,
                        output logic ack, output logic [23:0] data);
        logic s;
        logic [7:0] q;
        data = 24'h0;
        sda_low = 1'h0;
        scl = 1'h1;
        half();
        sda_low = 1'h1;
        half();
        scl = 1'h0;
        repeat (2) @(negedge sys_clk);
        io_byte(addr, q);
        bit_io(1'h1, s);
        ack = !s;
        if (ack && !addr[0]) begin
            io_byte(c, q);
            bit_io(1'h1, s);
            ack = !s;
        end
        for (int k = 0; k < nrd && ack; k++) begin
            io_byte(8'hff, q);
            data = {data[15:0], q};
            bit_io(k == nrd - 1, s);
        end
        sda_low = 1'h1;
        half();
        scl = 1'h1;
        half();
        sda_low = 1'h0;
        half();
    endtask : xfer
endmodule : scu_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the sensor command unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import scu_pkg::*;
    localparam int CONVERSION_SELECT_BIT_CYC = 20;
    localparam logic [111:0] IMG = {16'h6e5d, 16'h5c4b, 16'h4a39, 16'h3928, 16'h2817, 16'h1706, 16'hf5e4};
    logic sys_clk, osc_clk, rstn, scl, sda_low, sda_wire, sda_out, sda_oe, conversion_select_bit_active, conversion_select_bit_is_temp;
    logic [2:0] conversion_select_bit_ratio;
    logic [23:0] adc_data;
    int error_cnt, num_checks, cyc;
    assign sda_wire = !((sda_oe && !sda_out) || sda_low);
    scu_cmd_unit #(.CONVERSION_SELECT_BIT_CYCLES(CONVERSION_SELECT_BIT_CYC), .FACTORY_IMAGE(IMG)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .adc_data(adc_data), .conversion_select_bit_active(conversion_select_bit_active), .conversion_select_bit_is_temp(conversion_select_bit_is_temp), .conversion_select_bit_ratio(conversion_select_bit_ratio));
    scu_host_model u_host (.sys_clk(sys_clk), .sda(sda_wire), .scl(scl), .sda_low(sda_low));
    always #2 sys_clk = ~sys_clk;
    initial begin
        osc_clk = 1'h0;
        #1;
        forever #6 osc_clk = ~osc_clk;
    end
    task automatic end_of_test;
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [3:0] crc_of(input logic [111:0] img);
        logic [15:0] rem;
        logic [127:0] all;
        all = {16'h0, img[111:16], img[15:0] & 16'h0fff};
        rem = 16'h0;
        for (int c = 0; c < 16; c++) begin
            rem ^= {8'h0, all[16 * (c / 2) + 8 * (1 - c % 2) +: 8]};
            for (int b = 0; b < 8; b++) rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
        end
        return rem[15:12];
    endfunction : crc_of
    task automatic cmd(input logic [7:0] c);
        logic a;
        logic [23:0] d;
        u_host.xfer(8'hec, c, 0, a, d);
        check("command ack", {23'h0, a}, 24'h1);
    endtask : cmd
    task automatic rd(input int n, output logic [23:0] d);
        logic a;
        u_host.xfer(8'hed, 8'h0, n, a, d);
        check("read ack", {23'h0, a}, 24'h1);
    endtask : rd
    task automatic wait_busy(input logic v);
        for (int n = 0; n < 4000 && conversion_select_bit_active !== v; n++) @(negedge sys_clk);
        if (!v) repeat (10) @(negedge sys_clk);
    endtask : wait_busy
    task automatic t_addr;
        logic a;
        logic [23:0] d;
        u_host.xfer(8'hee, 8'h1e, 0, a, d);
        check("foreign address ack", {23'h0, a}, 24'h0);
    endtask : t_addr
    task automatic t_prom;
        logic [23:0] d;
        logic [111:0] img;
        cmd(8'ha0);
        rd(2, d);
        check("word before reload", d, 24'h0);
        cmd(8'h1e);
        img = {IMG[111:16], crc_of(IMG), IMG[11:0]};
        for (int i = 0; i < 8; i++) begin
            cmd(8'ha0 | 8'(2 * i));
            rd(2, d);
            check("calibration word", d, i < 7 ? {8'h0, img[16 * i +: 16]} : 24'h0);
        end
    endtask : t_prom
    task automatic t_conversion_select_bit;
        logic [23:0] d;
        logic [7:0] c;
        for (int k = 0; k < 12; k++) begin
            c = 8'h40 + 8'(16 * (k / 6) + 2 * (k % 6));
            adc_data = {c, 8'h5a, 8'(k)};
            cmd(c);
            wait_busy(1'h1);
            check("kind", {23'h0, conversion_select_bit_is_temp}, 24'(k / 6));
            check("ratio", {21'h0, conversion_select_bit_ratio}, 24'(k % 6));
            wait_busy(1'h0);
            cmd(8'h0);
            rd(3, d);
            check("result", d, adc_data);
            cmd(8'h0);
            rd(3, d);
            check("repeated read", d, 24'h0);
        end
    endtask : t_conversion_select_bit
    task automatic t_busy;
        logic [23:0] d;
        adc_data = 24'h3c5a96;
        cmd(8'h4a);
        cmd(8'h0);
        rd(3, d);
        check("read while busy", d, 24'h0);
        wait_busy(1'h0);
        cmd(8'h0);
        rd(3, d);
        check("spoiled result", d, ~adc_data);
        cmd(8'h5a);
        cmd(8'h5a);
        wait_busy(1'h0);
        cmd(8'h0);
        rd(3, d);
        check("double start", d, ~adc_data);
        cmd(8'h58);
        cmd(8'h1e);
        wait_busy(1'h0);
        cmd(8'h0);
        rd(3, d);
        check("reset mid conversion", d, 24'h0);
        // Ratio field 6 is outside the six ratios and must not start anything
        cmd(8'h4c);
        repeat (40) @(negedge sys_clk);
        check("refused ratio", {23'h0, conversion_select_bit_active}, 24'h0);
        rd(3, d);
        check("read after unknown command", d, 24'h0);
    endtask : t_busy
    initial begin
        sys_clk = 1'h0;
        rstn = 1'h0;
        adc_data = 24'h0;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        repeat (5) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (5) @(negedge sys_clk);
        t_addr();
        t_prom();
        t_conversion_select_bit();
        t_busy();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
